// file: verilog/subtract_alu_ops.sv
/*
  Subtract datapath slice: literal minus accumulator and register minus accumulator.
  Assumes the decoder presents one instruction per clock with insn_valid, and the register
  file returns the addressed register combinationally on file_rdata.
*/
// Notes on behaviour
// [RULE1] Literal-subtract computes immediate minus accumulator.
// [RULE2] Literal-subtract writes accumulator, no file write.
// [RULE3] Register-subtract: register minus accumulator, d=0 to accumulator.
// [RULE4] d=1 writes register, accumulator kept.
// [RULE5] Carry set when minuend exceeds subtrahend.
// [RULE6] Carry set when operands equal.
// [RULE7] Carry cleared on borrow; result wraps.
// [RULE8] Zero, nibble carry updated; one cycle each.
`timescale 1ns/1ps
`default_nettype none
module subtract_alu_ops
  import sub_alu_pkg::*;
(
  input wire logic clock,  // Instruction clock, 125 MHz.
  input wire logic rst,  // Synchronous active-high reset.
  input wire logic insn_valid,  // Instruction word is valid this cycle.
  input wire logic [sub_alu_pkg::INSN_W-1:0] insn,  // Instruction word.
  input wire logic [sub_alu_pkg::DATA_W-1:0] file_rdata,  // Addressed register value.
  output logic [sub_alu_pkg::ADDR_W-1:0] file_raddr,  // Read address, registered.
  output logic [sub_alu_pkg::DATA_W-1:0] acc,  // Working accumulator.
  output logic file_we,  // One-cycle register file write strobe.
  output logic [sub_alu_pkg::ADDR_W-1:0] file_waddr,  // Write address.
  output logic [sub_alu_pkg::DATA_W-1:0] file_wdata,  // Write data.
  output logic status_we,  // One-cycle flag update strobe.
  output logic carry_flag,  // Carry, an inverted borrow.
  output logic nibble_carry_flag,  // Low-nibble inverted borrow.
  output logic zero_flag  // Result was zero.
);
  import sub_alu_pkg::*;

  sub_op_t op;  // Decoded operation of the current word.
  logic [7:0] minuend;  // Selected minuend.
  logic [7:0] diff;  // Subtractor result.
  logic carry;  // Subtractor carry.
  logic nib;  // Subtractor nibble carry.
  logic zero;  // Subtractor zero.
  logic to_file;  // Register-subtract with destination bit set.

  // Decode the opcode; bit 8 of the literal form is ignored on purpose.
  always_comb begin
    if (insn_valid && insn[LIT_OP_MSB:LIT_OP_LSB] == LIT_OP_CODE) begin
      op = OP_LIT;  // [RULE1]
    end else if (insn_valid && insn[LIT_OP_MSB:REG_OP_LSB] == REG_OP_CODE) begin
      op = OP_REG;  // [RULE3]
    end else begin
      op = OP_NONE;
    end
  end

  // Literal comes from the word; register operand from the file read port.
  always_comb begin
    case (op)
      OP_LIT: minuend = insn[7:0];  // [RULE1]
      OP_REG: minuend = file_rdata;  // [RULE3]
      default: minuend = 8'h00;
    endcase
    to_file = (op == OP_REG) && insn[DEST_BIT];
  end

  // A combinational echo of the address would not come from a flop, so the register file
  // is expected to decode the address field of insn itself; this copy is only for
  // observation one cycle later.
  always_ff @(posedge clock) begin
    if (rst) begin
      file_raddr <= ADDR_RESET;
    end else begin
      file_raddr <= insn[ADDR_W-1:0];
    end
  end

  sub_core u_core (
    .minuend(minuend),
    .subtrahend(acc),
    .diff(diff),
    .carry(carry),
    .nibble_carry(nib),
    .zero(zero)
  );

  // Accumulator: written by the literal form and by the register form with d clear.
  always_ff @(posedge clock) begin
    if (rst) begin
      acc <= ACC_RESET;
    end else if (op == OP_LIT || (op == OP_REG && !to_file)) begin
      acc <= diff;  // [RULE2] [RULE3]
    end
  end

  // File write port: only the register form with d set writes, and then acc is kept.
  always_ff @(posedge clock) begin
    if (rst) begin
      file_we <= 1'b0;
      file_waddr <= ADDR_RESET;
      file_wdata <= 8'h00;
    end else begin
      file_we <= to_file;  // [RULE4] [RULE2]
      if (to_file) begin
        file_waddr <= insn[ADDR_W-1:0];  // [RULE4]
        file_wdata <= diff;
      end
    end
  end

  // Flags: carry is an inverted borrow, so equal or larger minuend gives one.
  always_ff @(posedge clock) begin
    if (rst) begin
      status_we <= 1'b0;
      carry_flag <= 1'b0;
      nibble_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
    end else begin
      status_we <= (op != OP_NONE);  // [RULE8]
      if (op != OP_NONE) begin
        carry_flag <= carry;  // [RULE5] [RULE6] [RULE7]
        nibble_carry_flag <= nib;  // [RULE8]
        zero_flag <= zero;  // [RULE8]
      end
    end
  end

  // Helper copies of the operands for the checks below.
  logic [7:0] past_min;  // Minuend of the previous cycle.
  logic [7:0] past_sub;  // Subtrahend of the previous cycle.
  logic past_lit;  // Previous word was literal form.
  logic past_file;  // Previous word wrote the file.
  always_ff @(posedge clock) begin
    if (rst) begin
      past_min <= 8'h00;
      past_sub <= 8'h00;
      past_lit <= 1'b0;
      past_file <= 1'b0;
    end else begin
      past_min <= minuend;
      past_sub <= acc;
      past_lit <= (op == OP_LIT);
      past_file <= to_file;
    end
  end

  property p_lit_result;
    @(posedge clock) disable iff (rst) past_lit |-> acc == 8'(past_min - past_sub);
  endproperty
  a_lit_result: assert property (p_lit_result) else $error("literal result wrong"); // [RULE1]
  property p_lit_nowrite;
    @(posedge clock) disable iff (rst) past_lit |-> !file_we;
  endproperty
  a_lit_nowrite: assert property (p_lit_nowrite) else $error("literal wrote file"); // [RULE2]
  property p_reg_acc;
    @(posedge clock) disable iff (rst)
      (op == OP_REG && !to_file) |=> acc == 8'(past_min - past_sub) && !file_we;
  endproperty
  a_reg_acc: assert property (p_reg_acc) else $error("reg to acc wrong"); // [RULE3]
  property p_reg_file;
    @(posedge clock) disable iff (rst)
      to_file |=> file_we && file_wdata == 8'(past_min - past_sub) && $stable(acc);
  endproperty
  a_reg_file: assert property (p_reg_file) else $error("reg to file wrong"); // [RULE4]
  property p_c_gt;
    @(posedge clock) disable iff (rst) status_we && past_min > past_sub |-> carry_flag;
  endproperty
  a_c_gt: assert property (p_c_gt) else $error("carry not set on positive"); // [RULE5]
  property p_c_eq;
    @(posedge clock) disable iff (rst)
      status_we && past_min == past_sub |-> carry_flag && zero_flag;
  endproperty
  a_c_eq: assert property (p_c_eq) else $error("carry or zero wrong on equal"); // [RULE6]
  property p_c_lt;
    @(posedge clock) disable iff (rst) status_we && past_min < past_sub |-> !carry_flag;
  endproperty
  a_c_lt: assert property (p_c_lt) else $error("carry not cleared on borrow"); // [RULE7]
  property p_nib;
    @(posedge clock) disable iff (rst)
      status_we |-> nibble_carry_flag == (past_min[3:0] >= past_sub[3:0]);
  endproperty
  a_nib: assert property (p_nib) else $error("nibble carry wrong"); // [RULE8]
  property p_onecycle;
    @(posedge clock) disable iff (rst) (op != OP_NONE) |=> status_we;
  endproperty
  a_onecycle: assert property (p_onecycle) else $error("flags late"); // [RULE8]
  // Decode checks read the raw word, not op, so a broken decoder cannot hide behind the
  // result checks above, which reuse the selected minuend.
  property p_lit_decode;
    @(posedge clock) disable iff (rst)
      (insn_valid && insn[LIT_OP_MSB:LIT_OP_LSB] == LIT_OP_CODE)
        |-> op == OP_LIT && minuend == insn[7:0];
  endproperty
  a_lit_decode: assert property (p_lit_decode) else $error("literal decode wrong"); // [RULE1]
  property p_reg_decode;
    @(posedge clock) disable iff (rst)
      (insn_valid && insn[LIT_OP_MSB:REG_OP_LSB] == REG_OP_CODE)
        |-> op == OP_REG && minuend == file_rdata && to_file == insn[DEST_BIT];
  endproperty
  a_reg_decode: assert property (p_reg_decode) else $error("register decode wrong"); // [RULE3]
  // Words that are not subtracts, or not valid, must leave the datapath alone.
  property p_refused;
    @(posedge clock) disable iff (rst)
      (!insn_valid || (insn[LIT_OP_MSB:LIT_OP_LSB] != LIT_OP_CODE
        && insn[LIT_OP_MSB:REG_OP_LSB] != REG_OP_CODE))
        |=> !status_we && !file_we && $stable(acc);
  endproperty
  a_refused: assert property (p_refused) else $error("refused word changed state"); // [RULE2]
  // Zero is judged on the wrapped difference, so a borrow to 0xFF does not count.
  property p_zero;
    @(posedge clock) disable iff (rst)
      status_we |-> zero_flag == (8'(past_min - past_sub) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RULE8]
  // Between subtracts the flags keep their last value.
  property p_flags_hold;
    @(posedge clock) disable iff (rst)
      !status_we |-> $stable({carry_flag, nibble_carry_flag, zero_flag});
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags moved"); // [RULE8]

  c_lit: cover property (@(posedge clock) disable iff (rst) past_lit);
  c_file: cover property (@(posedge clock) disable iff (rst) past_file);
  c_borrow: cover property (@(posedge clock) disable iff (rst) status_we && !carry_flag);
  c_equal: cover property (@(posedge clock) disable iff (rst) status_we && zero_flag);
  c_reg_acc: cover property (@(posedge clock) disable iff (rst) op == OP_REG && !to_file);
endmodule : subtract_alu_ops
`default_nettype wire

// file: inc/sub_alu_pkg.sv
/*
  Shared constants for the subtract datapath slice: opcode fields, widths and reset values.
  Assumes a 14-bit instruction word delivered whole by the decoder each instruction cycle.
*/
package sub_alu_pkg;
  localparam int DATA_W = 8;  // Width of the datapath.
  localparam int ADDR_W = 7;  // Width of a file register address.
  localparam int INSN_W = 14;  // Width of an instruction word.
  localparam int LIT_OP_MSB = 13;  // Top bit of the literal-subtract opcode field.
  localparam int LIT_OP_LSB = 9;  // Low bit of that field; bit 8 is a don't-care.
  localparam logic [4:0] LIT_OP_CODE = 5'h1E;  // Literal-subtract code, 11 110x.
  localparam int REG_OP_LSB = 8;  // Low bit of the register-subtract opcode field.
  localparam logic [5:0] REG_OP_CODE = 6'h02;  // Register-subtract code, 00 0010.
  localparam int DEST_BIT = 7;  // Destination select bit position.
  localparam logic [7:0] ACC_RESET = 8'h00;  // Accumulator value after reset.
  localparam logic [6:0] ADDR_RESET = 7'h00;  // Write address value after reset.
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_LIT = 2'b01,
    OP_REG = 2'b10
  } sub_op_t;  // Decoded operation class.
endpackage : sub_alu_pkg

// file: verilog/sub_core.sv
/*
  Combinational subtractor returning difference, inverted borrows and zero.
  Assumes its operands are stable during the cycle in which they are used.
*/
`timescale 1ns/1ps
`default_nettype none
module sub_core (
  input wire logic [7:0] minuend,  // Value subtracted from.
  input wire logic [7:0] subtrahend,  // Value subtracted.
  output logic [7:0] diff,  // Difference modulo 256.
  output logic carry,  // One when no borrow out of bit 7.
  output logic nibble_carry,  // One when no borrow out of bit 3.
  output logic zero  // One when the difference is zero.
);
  logic [8:0] full;  // Nine-bit sum of minuend and inverted subtrahend plus one.
  logic [4:0] low;  // Five-bit low nibble sum.
  // Two's complement: adding the inverse plus one makes carry an inverted borrow.
  always_comb begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    diff = full[7:0];
    carry = full[8];
    nibble_carry = low[4];
    zero = (full[7:0] == 8'h00);
  end
endmodule : sub_core
`default_nettype wire

// file: testbench/subtract_alu_ops_tb_top.sv
/*
  Self-checking bench for the subtract slice: corner cases, then seeded random traffic.
  Assumes the design takes one instruction per rising edge and answers one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module subtract_alu_ops_tb_top;
  import sub_alu_pkg::*;
  logic clock, rst, insn_valid;  // Clock, reset and valid strobe.
  logic [INSN_W-1:0] insn;  // Instruction word driven in.
  logic [DATA_W-1:0] file_rdata, acc, file_wdata, model_acc;  // Data paths and model.
  logic [ADDR_W-1:0] file_raddr, file_waddr;  // Register addresses.
  logic file_we, status_we, carry_flag, nibble_carry_flag, zero_flag;  // Strobes, flags.
  logic [2:0] model_flags;  // Expected carry, nibble carry and zero.
  int err_total, compares;  // Mismatch and comparison counts.
  subtract_alu_ops u_dut (.clock(clock), .rst(rst), .insn_valid(insn_valid), .insn(insn),
    .file_rdata(file_rdata), .file_raddr(file_raddr), .acc(acc), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .status_we(status_we),
    .carry_flag(carry_flag), .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag));
  // The clock toggles every 4 ns, half of its 8 ns period.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Packs carry, nibble carry, zero and the difference of m minus s.
  function automatic logic [10:0] expect_sub(input logic [7:0] m, input logic [7:0] s);
    logic [7:0] d;
    d = m - s;
    return {m >= s, m[3:0] >= s[3:0], d == 8'h00, d};
  endfunction : expect_sub
  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Prints the verdict and stops the run.
  task automatic give_verdict;
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // Kind 1 literal, 2 register, 0 another opcode, 3 literal with valid low.
  task automatic run_op(input logic [1:0] kind, input logic [7:0] k, input logic d,
                        input logic [6:0] a, input logic [7:0] f);
    logic [10:0] e;
    logic [7:0] old;
    logic sub;
    old = model_acc;
    sub = (kind == 2'h1) || (kind == 2'h2);
    e = expect_sub((kind == 2'h2) ? f : k, old);
    insn_valid = (kind != 2'h3);
    file_rdata = f;
    insn = (kind == 2'h2) ? {6'h02, d, a} : (kind == 2'h0) ? {6'h3A, k} : {5'h1E, d, k};
    @(negedge clock);
    chk({7'h00, status_we}, {7'h00, sub});
    chk({1'b0, file_raddr}, {1'b0, insn[6:0]});
    if (sub) begin
      model_flags = e[10:8];
    end
    chk({5'h00, carry_flag, nibble_carry_flag, zero_flag}, {5'h00, model_flags});
    if (kind == 2'h2 && d) begin
      chk({7'h00, file_we}, 8'h01);
      chk({1'b0, file_waddr}, {1'b0, a});
      chk(file_wdata, e[7:0]);
      chk(acc, old);
    end else begin
      chk({7'h00, file_we}, 8'h00);
      if (sub) begin
        model_acc = e[7:0];
      end
      chk(acc, model_acc);
    end
  endtask : run_op
  // A hang counts as a mismatch and ends the run through the same verdict.
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    give_verdict();
  end
  // Reset, worked corner cases, then random traffic fed back to back.
  initial begin
    err_total = 0;
    compares = 0;
    rst = 1'b1;
    insn_valid = 1'b0;
    insn = 14'h0000;
    file_rdata = 8'h00;
    void'($urandom(97104));
    repeat (5) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    chk(acc, ACC_RESET);
    chk({3'h0, file_we, status_we, carry_flag, nibble_carry_flag, zero_flag}, 8'h00);
    model_acc = ACC_RESET;
    model_flags = 3'b000;
    run_op(2'h1, 8'h01, 1'b0, 7'h00, 8'h00);
    run_op(2'h1, 8'h02, 1'b1, 7'h00, 8'h00);
    run_op(2'h1, 8'h01, 1'b0, 7'h00, 8'h00);
    run_op(2'h1, 8'h02, 1'b0, 7'h00, 8'h00);
    run_op(2'h2, 8'h00, 1'b1, 7'h7F, 8'h01);
    run_op(2'h2, 8'h00, 1'b0, 7'h05, 8'h10);
    run_op(2'h0, 8'hAF, 1'b0, 7'h00, 8'h00);
    run_op(2'h3, 8'h55, 1'b0, 7'h00, 8'h00);
    repeat (400) begin
      run_op(2'($urandom_range(0, 3)), 8'($urandom), 1'($urandom), 7'($urandom),
             8'($urandom));
    end
    give_verdict();
  end
endmodule : subtract_alu_ops_tb_top
`default_nettype wire
